/* rtl/pogh_output_gate.sv */
// Six-phase PWM output gating with high-impedance emergency control
`timescale 1ns/1ps
module pogh_output_gate
  import pogh_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [31:0] busAddr,
  input wire logic [7:0] busWdata,
  input wire logic busWr,
  input wire logic busRd,
  input wire logic busBitMode,
  input wire logic [2:0] busBitSel,
  output logic [7:0] busRdata,
  input wire logic timerRunEnable,
  input wire logic [2:0] upperPosPhase,
  input wire logic [2:0] upperNegPhase,
  input wire logic [2:0] lowerPosPhase,
  input wire logic [2:0] lowerNegPhase,
  input wire logic [2:0] upperIsOutput,
  input wire logic [2:0] lowerIsOutput,
  input wire logic singlePhaseLevel,
  input wire logic singleIsOutput,
  input wire logic faultInput,
  output logic [2:0] upperArmPin,
  output logic [2:0] upperArmPinOe,
  output logic [2:0] lowerArmPin,
  output logic [2:0] lowerArmPinOe,
  output logic singlePhaseTimerPin,
  output logic singlePhaseTimerPinOe
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [7:0] lowerArmOutputControl_q;
  logic [7:0] upperArmOutputControl_q;
  pogh_hiz_cfg_t hizCfg_q [POGH_HZ_UNITS];
  pogh_hiz_cmd_t hizCmd [POGH_HZ_UNITS];
  logic [POGH_HZ_UNITS-1:0] hizFlag;
  logic faultMeta_q;
  logic faultSync_q;
  logic faultPrev_q;
  logic [7:0] busRdata_q;
  logic [7:0] rdByte;
  logic selLower;
  logic selUpper;
  logic [POGH_HZ_UNITS-1:0] selHiz;
  logic [2:0] upperPin_d;
  logic [2:0] lowerPin_d;
  logic [2:0] upperPin_q;
  logic [2:0] lowerPin_q;
  logic [2:0] upperOe_q;
  logic [2:0] lowerOe_q;
  logic singlePin_q;
  logic singleOe_q;

  // Byte write, or single-bit write of wdata[0] into the selected bit
  function automatic logic [7:0] mergeWrite(input logic [7:0] old,
                                            input logic [7:0] wd,
                                            input logic bitMode,
                                            input logic [2:0] sel);
    logic [7:0] res;
    res = old;
    if (bitMode)
      res[sel] = wd[0];
    else
      res = wd;
    return res;
  endfunction : mergeWrite

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; the bus is eight bits wide, so no 16-bit access exists
  assign selLower = busAddr == POGH_ADDR_LOWER;
  assign selUpper = busAddr == POGH_ADDR_UPPER;
  assign selHiz[0] = busAddr == POGH_ADDR_HIZ0;
  assign selHiz[1] = busAddr == POGH_ADDR_HIZ1;

  ////////////////////////////////////////////////////////////////////////////
  // Fault pin synchroniser; prev stage feeds the edge detector
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      faultMeta_q <= 1'b0;
      faultSync_q <= 1'b0;
      faultPrev_q <= 1'b0;
    end
    else
    begin
      faultMeta_q <= faultInput;
      faultSync_q <= faultMeta_q;
      faultPrev_q <= faultSync_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lower-arm register: frozen while the timer runs, so every write
  // is ignored then; bits 1:0 are masked to zero
  always_ff @(posedge clk)
  begin
    if (!nrst)
      lowerArmOutputControl_q <= POGH_LOWER_RST;
    else if (busWr && selLower && !timerRunEnable)
      lowerArmOutputControl_q <= POGH_ARM_MASK &
        mergeWrite(lowerArmOutputControl_q, busWdata, busBitMode,
                   busBitSel);
  end

  // Upper-arm register; software is expected to enable here first
  always_ff @(posedge clk)
  begin
    if (!nrst)
      upperArmOutputControl_q <= POGH_UPPER_RST;
    else if (busWr && selUpper)
      upperArmOutputControl_q <= POGH_ARM_MASK &
        mergeWrite(upperArmOutputControl_q, busWdata, busBitMode,
                   busBitSel);
  end

  ////////////////////////////////////////////////////////////////////////////
  // High-impedance registers, one controller each, sharing the fault pin
  genvar u;
  generate
    for (u = 0; u < POGH_HZ_UNITS; u++)
    begin : g_hiz
      logic [7:0] cur;
      logic [7:0] wr;
      assign cur = {hizCfg_q[u], 1'b0, 1'b0, 1'b0, hizFlag[u]};
      assign wr = mergeWrite(cur, busWdata, busBitMode, busBitSel);
      // Command bits act only on a write that carries a 1 in them
      assign hizCmd[u].trigger = busWr && selHiz[u] &&
                                 wr[POGH_HZ_TRIG];
      assign hizCmd[u].clear = busWr && selHiz[u] &&
                               wr[POGH_HZ_CLR];

      // Rewriting read contents never fires a command: those bits read 0
      always_ff @(posedge clk)
      begin
        if (!nrst)
          hizCfg_q[u] <= POGH_HIZ_CFG_RST;
        else if (busWr && selHiz[u])
          hizCfg_q[u] <= wr[POGH_HZ_EN:POGH_HZ_RISE];
      end

      pogh_hiz_unit u_hiz (
        .clk(clk),
        .nrst(nrst),
        .cfg(hizCfg_q[u]),
        .cmd(hizCmd[u]),
        .faultLvl(faultSync_q),
        .faultPrev(faultPrev_q),
        .flag(hizFlag[u])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; flag is visible, command bits and bit 1 read zero
  always_comb
  begin
    rdByte = 8'h00;
    if (selLower)
      rdByte = lowerArmOutputControl_q;
    else if (selUpper)
      rdByte = upperArmOutputControl_q;
    else if (selHiz[0])
      rdByte = g_hiz[0].cur;
    else if (selHiz[1])
      rdByte = g_hiz[1].cur;
    if (busBitMode)
      rdByte = {7'h00, rdByte[busBitSel]};
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!nrst)
      busRdata_q <= 8'h00;
    else if (busRd)
      busRdata_q <= rdByte;
    else
      busRdata_q <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-phase level selection from the truth table
  genvar p;
  generate
    for (p = 0; p < POGH_PHASES; p++)
    begin : g_phase
      pogh_arm_ctrl_t up;
      pogh_arm_ctrl_t lo;
      assign up = upperArmOutputControl_q[POGH_ARM_BASE+2*p +: 2];
      assign lo = lowerArmOutputControl_q[POGH_ARM_BASE+2*p +: 2];
      // Stopped timer or disabled pin: the invert bit is the level
      assign upperPin_d[p] = (up.enable && timerRunEnable) ?
        (up.invert ? upperNegPhase[p] : upperPosPhase[p]) :
        up.invert;
      assign lowerPin_d[p] = (lo.enable && timerRunEnable) ?
        (lo.invert ? lowerNegPhase[p] : lowerPosPhase[p]) :
        lo.invert;
    end
  endgenerate

  // Pin drivers; flag 1 drops the arm buffer enables, flag 0 the single-phase one, output pins only
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      upperPin_q <= 3'h0;
      lowerPin_q <= 3'h0;
      upperOe_q <= 3'h0;
      lowerOe_q <= 3'h0;
      singlePin_q <= 1'b0;
      singleOe_q <= 1'b0;
    end
    else
    begin
      upperPin_q <= upperPin_d;
      lowerPin_q <= lowerPin_d;
      upperOe_q <= upperIsOutput & {3{~hizFlag[1]}};
      lowerOe_q <= lowerIsOutput & {3{~hizFlag[1]}};
      singlePin_q <= singlePhaseLevel;
      singleOe_q <= singleIsOutput & ~hizFlag[0];
    end
  end

  assign busRdata = busRdata_q;
  assign upperArmPin = upperPin_q;
  assign lowerArmPin = lowerPin_q;
  assign upperArmPinOe = upperOe_q;
  assign lowerArmPinOe = lowerOe_q;
  assign singlePhaseTimerPin = singlePin_q;
  assign singlePhaseTimerPinOe = singleOe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_lowerWriteRunning;
    busWr && selLower && timerRunEnable;
  endsequence

  property p_lowerFrozen;
    @(posedge clk) disable iff (!nrst)
      s_lowerWriteRunning |=> $stable(lowerArmOutputControl_q);
  endproperty
  a_lowerFrozen: assert property (p_lowerFrozen)
    else $error("lower-arm register changed while timer ran");

  property p_lowerLowBits;
    @(posedge clk) disable iff (!nrst)
      busWr && selLower |=> lowerArmOutputControl_q[1:0] == 2'h0;
  endproperty
  a_lowerLowBits: assert property (p_lowerLowBits)
    else $error("lower-arm bits 1:0 not zero");

  // Pins leave reset low, so the release edge itself is not judged
  property p_lowerStatic;
    @(posedge clk) disable iff (!nrst)
      nrst && !(lowerArmOutputControl_q[2] && timerRunEnable)
      |=> lowerArmPin[0] == $past(lowerArmOutputControl_q[3]);
  endproperty
  a_lowerStatic: assert property (p_lowerStatic)
    else $error("lower phase 1 static level wrong");

  property p_lowerRun;
    @(posedge clk) disable iff (!nrst)
      lowerArmOutputControl_q[2] && timerRunEnable
      |=> lowerArmPin[0] == ($past(lowerArmOutputControl_q[3]) ?
          $past(lowerNegPhase[0]) : $past(lowerPosPhase[0]));
  endproperty
  a_lowerRun: assert property (p_lowerRun)
    else $error("lower phase 1 waveform wrong");

  property p_upperRun;
    @(posedge clk) disable iff (!nrst)
      upperArmOutputControl_q[7:6] == 2'h1 && timerRunEnable
      |=> upperArmPin[2] == $past(upperPosPhase[2]);
  endproperty
  a_upperRun: assert property (p_upperRun)
    else $error("upper phase 3 waveform wrong");

  property p_floatArms;
    @(posedge clk) disable iff (!nrst)
      hizFlag[1] |=> upperArmPinOe == 3'h0 && lowerArmPinOe == 3'h0;
  endproperty
  a_floatArms: assert property (p_floatArms)
    else $error("arm pins driven while floated");

  property p_readZeros;
    @(posedge clk) disable iff (!nrst)
      busRd && (selHiz != 2'h0) && !busBitMode
      |=> busRdata[3:1] == 3'h0 && busRdata[0] == $past(hizFlag[1] &
          selHiz[1] | hizFlag[0] & selHiz[0]);
  endproperty
  a_readZeros: assert property (p_readZeros)
    else $error("high-impedance register read back wrong");

endmodule : pogh_output_gate

/* rtl/pogh_pkg.sv */
// Package: register map, field layout and shared types of the output gate
package pogh_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [31:0] POGH_ADDR_LOWER = 32'hFFFFF622;
  localparam logic [31:0] POGH_ADDR_HIZ0 = 32'hFFFFF630;
  localparam logic [31:0] POGH_ADDR_HIZ1 = 32'hFFFFF631;
  localparam logic [31:0] POGH_ADDR_UPPER = 32'hFFFFF640;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] POGH_LOWER_RST = 8'hA8;
  localparam logic [7:0] POGH_UPPER_RST = 8'h00;
  localparam logic [3:0] POGH_HIZ_CFG_RST = 4'h0;

  // Arm registers: bits 1:0 are tied to zero
  localparam logic [7:0] POGH_ARM_MASK = 8'hFC;

  ////////////////////////////////////////////////////////////////////////////
  // Arm register fields: phase m uses invert at 2m+1, enable at 2m
  localparam int POGH_ARM_BASE = 2;
  localparam int POGH_PHASES = 3;

  // High-impedance control register fields
  localparam int POGH_HZ_EN = 7;
  localparam int POGH_HZ_CLRCOND = 6;
  localparam int POGH_HZ_FALL = 5;
  localparam int POGH_HZ_RISE = 4;
  localparam int POGH_HZ_TRIG = 3;
  localparam int POGH_HZ_CLR = 2;
  localparam int POGH_HZ_FLAG = 0;
  localparam int POGH_HZ_UNITS = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Per-phase control pair taken from an arm register
  typedef struct packed {
    logic invert;
    logic enable;
  } pogh_arm_ctrl_t;

  // Stored configuration of one high-impedance controller
  typedef struct packed {
    logic enable;
    logic clearCond;
    logic fallSel;
    logic riseSel;
  } pogh_hiz_cfg_t;

  // One-cycle commands from a register write
  typedef struct packed {
    logic trigger;
    logic clear;
  } pogh_hiz_cmd_t;

endpackage : pogh_pkg

/* rtl/pogh_hiz_unit.sv */
// High-impedance controller: fault edge detect and status flag
`timescale 1ns/1ps
module pogh_hiz_unit
  import pogh_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input pogh_hiz_cfg_t cfg,
  input pogh_hiz_cmd_t cmd,
  input wire logic faultLvl,
  input wire logic faultPrev,
  output logic flag
);

  ////////////////////////////////////////////////////////////////////////////
  // Edge and level qualification of the synchronised fault input
  logic edgeHit;
  logic faultActive;
  logic setReq;
  logic clrOk;
  logic flag_q;
  logic flag_d;

  // Only a transition counts, so a level already active at enable is ignored
  assign edgeHit = (cfg.riseSel & faultLvl & ~faultPrev) |
                   (cfg.fallSel & ~faultLvl & faultPrev);
  assign faultActive = (cfg.riseSel & faultLvl) |
                       (cfg.fallSel & ~faultLvl);
  assign setReq = cfg.enable & (cmd.trigger | edgeHit);
  // With clearCond set, clear is refused while the fault holds its active level
  assign clrOk = cfg.enable & cmd.clear &
                 ~(cfg.clearCond & faultActive);

  // Flag update: disable clears, set beats clear so no event is lost
  always_comb
  begin
    flag_d = flag_q;
    if (!cfg.enable)
      flag_d = 1'b0;
    else if (setReq)
      flag_d = 1'b1;
    else if (clrOk)
      flag_d = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

  assign flag = flag_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_edgeSeen;
    cfg.enable && edgeHit;
  endsequence

  property p_edgeSets;
    @(posedge clk) disable iff (!nrst)
      s_edgeSeen |=> flag;
  endproperty
  a_edgeSets: assert property (p_edgeSets)
    else $error("fault edge did not set the flag");

  property p_trigSets;
    @(posedge clk) disable iff (!nrst)
      cfg.enable && cmd.trigger |=> flag;
  endproperty
  a_trigSets: assert property (p_trigSets)
    else $error("software trigger did not set the flag");

  property p_offClears;
    @(posedge clk) disable iff (!nrst)
      !cfg.enable |=> !flag;
  endproperty
  a_offClears: assert property (p_offClears)
    else $error("flag stayed set while disabled");

  property p_clearBlocked;
    @(posedge clk) disable iff (!nrst)
      cfg.enable && cfg.clearCond && faultActive && !setReq
      |=> flag == $past(flag);
  endproperty
  a_clearBlocked: assert property (p_clearBlocked)
    else $error("clear accepted while fault active");

  property p_clearTakes;
    @(posedge clk) disable iff (!nrst)
      cfg.enable && cmd.clear && !cfg.clearCond && !setReq |=> !flag;
  endproperty
  a_clearTakes: assert property (p_clearTakes)
    else $error("unconditional clear was not honoured");

endmodule : pogh_hiz_unit

/* sim/pogh_fault_src.sv */
// Far-side model: external fault source feeding the fault pin
`timescale 1ns/1ps
module pogh_fault_src (
  input wire logic clk,
  input wire logic req,
  input wire logic [3:0] lag,
  output logic faultInput
);
  logic [3:0] cntQ;
  initial faultInput = 1'h0;
  initial cntQ = 4'h0;
  // Pin follows the request lag+1 cycles later, like a slow fault sensor
  always @(posedge clk)
  begin
    if (req == faultInput)
      cntQ <= 4'h0;
    else if (cntQ >= lag)
    begin
      faultInput <= req;
      cntQ <= 4'h0;
    end
    else
      cntQ <= cntQ + 4'h1;
  end
endmodule : pogh_fault_src

/* sim/tb_pwm_output_gate_hiz_ctrl.sv */
// Self-checking bench for the six-phase output gate and float control
`timescale 1ns/1ps
module tb_pwm_output_gate_hiz_ctrl;
  import pogh_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [31:0] busAddr = 32'h0;
  logic [7:0] busWdata = 8'h00;
  logic busWr = 1'h0, busRd = 1'h0, busBitMode = 1'h0;
  logic [2:0] busBitSel = 3'h0;
  logic [7:0] busRdata;
  logic timerRunEnable = 1'h0;
  logic [2:0] upPos = 3'h5, upNeg = 3'h2, loPos = 3'h3, loNeg = 3'h6;
  logic [2:0] upOut = 3'h7, loOut = 3'h5;
  logic singleLvl = 1'h1, singleOut = 1'h1, faultReq = 1'h0;
  logic [3:0] faultLag = 4'h0;
  logic faultInput, singlePin, singleOe;
  logic [2:0] upPin, upOe, loPin, loOe;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;

  // Clock at 50 MHz
  always #10 clk = ~clk;

  pogh_fault_src fault_u (.clk(clk), .req(faultReq), .lag(faultLag),
    .faultInput(faultInput));

  pogh_output_gate dut_u (.clk(clk), .nrst(nrst), .busAddr(busAddr),
    .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
    .busBitMode(busBitMode), .busBitSel(busBitSel), .busRdata(busRdata),
    .timerRunEnable(timerRunEnable), .upperPosPhase(upPos),
    .upperNegPhase(upNeg), .lowerPosPhase(loPos), .lowerNegPhase(loNeg),
    .upperIsOutput(upOut), .lowerIsOutput(loOut),
    .singlePhaseLevel(singleLvl), .singleIsOutput(singleOut),
    .faultInput(faultInput), .upperArmPin(upPin), .upperArmPinOe(upOe),
    .lowerArmPin(loPin), .lowerArmPinOe(loOe),
    .singlePhaseTimerPin(singlePin), .singlePhaseTimerPinOe(singleOe));

  ////////////////////////////////////////////////////////////////////////////
  // Shared helpers
  task automatic chk(input string what, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One bus access; read data is taken in the cycle after the strobe
  task automatic acc(input logic wr, input logic [31:0] a,
      input logic [7:0] d, input logic bm, input logic [2:0] s,
      output logic [7:0] q);
    @(posedge clk);
    busWr <= wr;
    busRd <= !wr;
    busAddr <= a;
    busWdata <= d;
    busBitMode <= bm;
    busBitSel <= s;
    @(posedge clk);
    busWr <= 1'h0;
    busRd <= 1'h0;
    #1;
    q = busRdata;
  endtask : acc

  task automatic wr(input logic [31:0] a, input logic [7:0] d,
      input logic bm = 1'h0, input logic [2:0] s = 3'h0);
    logic [7:0] q;
    acc(1'h1, a, d, bm, s, q);
  endtask : wr

  task automatic rdc(input string what, input logic [31:0] a,
      input logic [7:0] exp, input logic bm = 1'h0,
      input logic [2:0] s = 3'h0);
    logic [7:0] q;
    acc(1'h0, a, 8'h00, bm, s, q);
    chk(what, exp, q);
  endtask : rdc

  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitc

  task automatic fset(input logic v, input logic [3:0] l);
    @(posedge clk);
    faultReq <= v;
    faultLag <= l;
    waitc(14);
  endtask : fset

  // Expected arm pins: invert at 2m+3, enable at 2m+2 of the register
  function automatic logic [2:0] arm(input logic [7:0] r, input logic run,
      input logic [2:0] p, n);
    for (int m = 0; m < 3; m++)
      arm[m] = (r[2*m+2] && run) ? (r[2*m+3] ? n[m] : p[m]) : r[2*m+3];
  endfunction : arm

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rdc("lower", POGH_ADDR_LOWER, 8'hA8);
    rdc("upper", POGH_ADDR_UPPER, 8'h00);
    rdc("hiz0", POGH_ADDR_HIZ0, 8'h00);
    rdc("hiz1", POGH_ADDR_HIZ1, 8'h00);
    rdc("unmapped", 32'hFFFFF632, 8'h00);
    $display("test reset done");
  endtask : t_reset

  // Every invert/enable pair, stopped and running
  task automatic t_table;
    logic [7:0] up [3] = '{8'h74, 8'h00, 8'hFC};
    logic [7:0] lo [3] = '{8'hD8, 8'hA8, 8'h57};
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      timerRunEnable <= 1'h0;
      wr(POGH_ADDR_UPPER, up[i]);
      wr(POGH_ADDR_LOWER, lo[i]);
      for (int r = 0; r < 2; r++)
      begin
        @(posedge clk);
        timerRunEnable <= r[0];
        waitc(3);
        chk("upperPin", {5'h0, arm(up[i], r[0], upPos, upNeg)},
            {5'h0, upPin});
        chk("lowerPin", {5'h0, arm(lo[i], r[0], loPos, loNeg)},
            {5'h0, loPin});
      end
    end
    // Running timer: a changing write is dropped, bits 1:0 read zero
    wr(POGH_ADDR_LOWER, 8'h00);
    rdc("lowerRun", POGH_ADDR_LOWER, 8'h54);
    chk("lowerOe", 8'h05, {5'h0, loOe});
    chk("singlePin", 8'h01, {7'h0, singlePin});
    $display("test table done");
  endtask : t_table

  task automatic t_bits;
    @(posedge clk);
    timerRunEnable <= 1'h0;
    wr(POGH_ADDR_LOWER, 8'hA8);
    wr(POGH_ADDR_LOWER, 8'h01, 1'h1, 3'h1);
    wr(POGH_ADDR_LOWER, 8'h01, 1'h1, 3'h6);
    rdc("lowerBits", POGH_ADDR_LOWER, 8'hE8);
    rdc("lowerBit7", POGH_ADDR_LOWER, 8'h01, 1'h1, 3'h7);
    wr(POGH_ADDR_HIZ0, 8'h01, 1'h1, 3'h0);
    rdc("hizFlagWr", POGH_ADDR_HIZ0, 8'h00);
    wr(POGH_ADDR_LOWER, 8'hA8);
    $display("test bits done");
  endtask : t_bits

  task automatic t_soft;
    @(posedge clk);
    loOut <= 3'h7;
    wr(POGH_ADDR_HIZ1, 8'h08);
    rdc("trigOff", POGH_ADDR_HIZ1, 8'h00);
    wr(POGH_ADDR_HIZ1, 8'h80);
    wr(POGH_ADDR_HIZ1, 8'h88);
    waitc(3);
    rdc("trig", POGH_ADDR_HIZ1, 8'h81);
    chk("upOe", 8'h00, {5'h0, upOe});
    chk("loOe", 8'h00, {5'h0, loOe});
    chk("singleOe", 8'h01, {7'h0, singleOe});
    wr(POGH_ADDR_HIZ1, 8'h80);
    rdc("sameWr", POGH_ADDR_HIZ1, 8'h81);
    wr(POGH_ADDR_HIZ1, 8'h84);
    waitc(3);
    rdc("clear", POGH_ADDR_HIZ1, 8'h80);
    chk("loOeBack", 8'h07, {5'h0, loOe});
    wr(POGH_ADDR_HIZ1, 8'h88);
    wr(POGH_ADDR_HIZ1, 8'h00);
    waitc(3);
    rdc("disable", POGH_ADDR_HIZ1, 8'h00);
    chk("loOeOff", 8'h07, {5'h0, loOe});
    $display("test soft done");
  endtask : t_soft

  task automatic t_fault;
    fset(1'h1, 4'h0);
    wr(POGH_ADDR_HIZ0, 8'hA0);
    fset(1'h0, 4'h5);
    rdc("fallEdge", POGH_ADDR_HIZ0, 8'hA1);
    chk("singleOe", 8'h00, {7'h0, singleOe});
    chk("armOe", 8'h07, {5'h0, loOe});
    wr(POGH_ADDR_HIZ0, 8'hA4);
    rdc("clrFree", POGH_ADDR_HIZ0, 8'hA0);
    wr(POGH_ADDR_HIZ0, 8'h00);
    fset(1'h1, 4'h0);
    wr(POGH_ADDR_HIZ1, 8'h50);
    wr(POGH_ADDR_HIZ1, 8'hD0);
    waitc(8);
    rdc("levelAtEn", POGH_ADDR_HIZ1, 8'hD0);
    fset(1'h0, 4'h0);
    fset(1'h1, 4'h2);
    rdc("riseEdge", POGH_ADDR_HIZ1, 8'hD1);
    chk("upOe", 8'h00, {5'h0, upOe});
    wr(POGH_ADDR_HIZ1, 8'hD4);
    rdc("clrBlocked", POGH_ADDR_HIZ1, 8'hD1);
    fset(1'h0, 4'h0);
    wr(POGH_ADDR_HIZ1, 8'hD4);
    rdc("clrLater", POGH_ADDR_HIZ1, 8'hD0);
    wr(POGH_ADDR_HIZ1, 8'h00);
    $display("test fault done");
  endtask : t_fault

  ////////////////////////////////////////////////////////////////////////////
  // Closing report, reached from the main run or the cycle ceiling
  task automatic end_sim;
    $display("Counts: %0d compared, %0d mismatched", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      end_sim();
    end
  end

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    t_reset();
    t_table();
    t_bits();
    t_soft();
    t_fault();
    end_sim();
  end
endmodule : tb_pwm_output_gate_hiz_ctrl
